// ---- hdl/host_bus_pkg.sv ----
package host_bus_pkg;

  // address widths of the host bus
  localparam int unsigned ADDR_W      = 20;
  localparam int unsigned IO_ADDR_W   = 16;

  // memory window decode fields (unlatched a19..a17, latched a19..a11)
  localparam int unsigned WIN_LSB     = 17;
  localparam int unsigned BUF_LSB     = 11;
  localparam int unsigned IO_LSB      = 2;

  // configuration register bit positions
  localparam int unsigned CFG_WAIT_BIT = 2;
  localparam int unsigned CFG_WIDE_BIT = 7;

  // ready-line wait: least time in crystal periods, 20 ns each
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned WAIT_MIN_XTAL   = 2;
  localparam int unsigned WAIT_MAX_XTAL   = 3;
  localparam int unsigned WAIT_CYCLES     = WAIT_MIN_XTAL;
  localparam logic [1:0]  WAIT_CNT_INIT   = 2'h0;

  // synchroniser depth and reset values
  localparam int unsigned SYNC_STAGES     = 3;
  localparam logic        WIDE_RESET      = 1'b0;

  // wait sequencer states
  typedef enum logic [1:0] {
    ws_idle,
    ws_hold,
    ws_done
  } wait_state_e;

endpackage

// ---- hdl/addr_latch_pair.sv ----
`timescale 1ns/1ps
// two address holding stages in series, sampled on the core clock
module addr_latch_pair
  import host_bus_pkg::*;
#(
  parameter int unsigned WIDTH = ADDR_W
) (
  // clock and control
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  // stage controls
  input  wire logic             first_open,
  input  wire logic             second_open,
  // address
  input  wire logic [WIDTH-1:0] addr_in,
  output logic      [WIDTH-1:0] addr_out
);

  logic [WIDTH-1:0] first_q;  // first stage, follows bale

  // [R14] first stage transparent
  // passes address while the stage control is high, holds when low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      first_q <= '0;
    end else if (clk_en && first_open) begin
      first_q <= addr_in;
    end
  end

  // [R7] second stage capture
  // open until the strobe leading edge, then holds; output registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_out <= '0;
    end else if (clk_en && second_open) begin
      addr_out <= first_open ? addr_in : first_q;
    end
  end

endmodule

// ---- hdl/host_bus_wait_and_latch.sv ----
`timescale 1ns/1ps
// Functional notes
// [R1] wait bit set: ready low two clocks
// [R2] ready low lasts two to three clocks
// [R3] same wait for every cycle type
// [R4] prom enable never affects ready timing
// [R5] strobe leading edge captures the address
// [R6] host holds bale high in 8-bit mode
// [R7] two address stages in series
// [R8] memory wide select from two decodes
// [R9] lane enables low after read strobe falls
// [R10] lane enables high when read strobe rises
// [R11] io wide select from a2-a15, aen low
// [R12] wide sense low before config write: 16-bit
// [R13] wait bit clear: ready stays high
// [R14] bale stage passes high, holds low
module host_bus_wait_and_latch
  import host_bus_pkg::*;
#(
  parameter logic [2:0] WIN_BASE = 3'h6,
  parameter logic [8:0] BUF_BASE = 9'h1a0,
  parameter logic [13:0] IO_BASE = 14'h00b8
) (
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              clk_en,
  // host bus pins
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic              bale,
  input  wire logic              aen,
  input  wire logic              mem_rd_n,
  input  wire logic              mem_wr_n,
  input  wire logic              io_rd_n,
  input  wire logic              io_wr_n,
  input  wire logic              prom_window_enable_n,
  input  wire logic              wide_bus_sense_n,
  // configuration register write port from the core
  input  wire logic              cfg_wr,
  input  wire logic [7:0]        cfg_wdata,
  // host bus outputs
  output logic                   iochrdy,
  output logic                   mem_wide_select_n,
  output logic                   io_wide_select_n,
  output logic                   upper_lane_buffer_en_n,
  output logic                   lower_lane_buffer_en_n,
  // status to the core
  output logic [ADDR_W-1:0]      latched_addr,
  output logic                   wide_mode,
  output logic                   wait_enable
);

  // three-stage synchronisers for pin inputs; stage 0 feeds only stage 1
  localparam int unsigned NSYNC = 6;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s0;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] pin_q;  // debounced level, stages 1 and 2 agree

  assign pin_raw = {wide_bus_sense_n, bale, mem_rd_n, mem_wr_n,
                    io_rd_n, io_wr_n};

  // synchroniser chain
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s0 <= '1;
      s1 <= '1;
      s2 <= '1;
    end else if (clk_en) begin
      s0 <= pin_raw;
      s1 <= s0;
      s2 <= s1;
    end
  end

  // per-bit agreement filter
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_filt
      always_ff @(posedge core_clk) begin
        if (srst) begin
          pin_q[g] <= 1'b1;
        end else if (clk_en && (s1[g] == s2[g])) begin
          pin_q[g] <= s2[g];
        end
      end
    end
  endgenerate

  logic sense_n_q;  // filtered wide sense
  logic bale_q;     // filtered bale
  logic mrd_q;      // filtered memory read strobe
  logic mwr_q;      // filtered memory write strobe
  logic ird_q;      // filtered io read strobe
  logic iwr_q;      // filtered io write strobe
  assign {sense_n_q, bale_q, mrd_q, mwr_q, ird_q, iwr_q} = pin_q;

  logic mrd_prev;   // previous read strobe level
  logic strobe_prev;
  logic any_strobe; // any host access strobe active
  logic lead_edge;  // leading edge of any access strobe
  logic mem_strobe; // memory strobe active

  assign mem_strobe = ~mrd_q | ~mwr_q;
  assign any_strobe = mem_strobe | ~ird_q | ~iwr_q;
  assign lead_edge  = any_strobe & ~strobe_prev;

  // strobe history for edge detection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mrd_prev    <= 1'b1;
      strobe_prev <= 1'b0;
    end else if (clk_en) begin
      mrd_prev    <= mrd_q;
      strobe_prev <= any_strobe;
    end
  end

  // configuration bits; cfg_written ends the sensing window
  logic cfg_written;

  // [R12] bus width default
  // sense low any time before first config write selects wide mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wide_mode   <= WIDE_RESET;
      cfg_written <= 1'b0;
      wait_enable <= 1'b0;
    end else if (clk_en) begin
      if (cfg_wr) begin
        wide_mode   <= cfg_wdata[CFG_WIDE_BIT];
        wait_enable <= cfg_wdata[CFG_WAIT_BIT];
        cfg_written <= 1'b1;
      end else if (!cfg_written && !sense_n_q) begin
        wide_mode <= 1'b1;
      end
    end
  end

  // [R5] strobe edge capture
  // second stage stays open while no memory strobe is active
  logic second_open;
  assign second_open = ~mem_strobe;

  // [R7] stage chaining
  // bale held high makes the first stage transparent throughout
  addr_latch_pair #(
    .WIDTH (ADDR_W)
  ) u_latch (
    .core_clk    (core_clk),
    .srst        (srst),
    .clk_en      (clk_en),
    .first_open  (bale_q),
    .second_open (second_open),
    .addr_in     (host_addr),
    .addr_out    (latched_addr)
  );

  // [R8] memory wide select
  // window on live a19..a17 plus buffer decode on held a19..a11
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_wide_select_n <= 1'b1;
    end else if (clk_en) begin
      mem_wide_select_n <=
        !((host_addr[ADDR_W-1:WIN_LSB] == WIN_BASE) &&
          (latched_addr[ADDR_W-1:BUF_LSB] == BUF_BASE));
    end
  end

  // [R11] io wide select
  // direct a15..a2 compare gated with aen low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_wide_select_n <= 1'b1;
    end else if (clk_en) begin
      io_wide_select_n <=
        !(!aen && (host_addr[IO_ADDR_W-1:IO_LSB] == IO_BASE));
    end
  end

  // answered memory cycle: buffer window hit on the held address
  logic mem_hit;
  assign mem_hit = (latched_addr[ADDR_W-1:BUF_LSB] == BUF_BASE) &&
                   (latched_addr[ADDR_W-1:WIN_LSB] == WIN_BASE);

  // [R9] lane enables on
  // [R10] lane enables off
  // falling read strobe on a hit turns both lanes on; rising turns off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upper_lane_buffer_en_n <= 1'b1;
      lower_lane_buffer_en_n <= 1'b1;
    end else if (clk_en) begin
      if (mrd_q) begin
        upper_lane_buffer_en_n <= 1'b1;
        lower_lane_buffer_en_n <= 1'b1;
      end else if (mrd_prev && mem_hit) begin
        upper_lane_buffer_en_n <= 1'b0;
        lower_lane_buffer_en_n <= 1'b0;
      end
    end
  end

  // wait sequencer; cycle type and prom enable are never consulted,
  // so every access sees the same ready-line wait
  wait_state_e state;
  logic [1:0]  wait_cnt;

  // [R3] uniform wait
  // [R4] prom enable ignored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state    <= ws_idle;
      wait_cnt <= WAIT_CNT_INIT;
    end else if (clk_en) begin
      case (state)
        ws_idle: begin
          // [R13] no wait added
          if (lead_edge && wait_enable) begin
            state    <= ws_hold;
            wait_cnt <= WAIT_CNT_INIT;
          end
        end
        ws_hold: begin
          wait_cnt <= wait_cnt + 2'h1;
          // [R1] two clock minimum
          if (wait_cnt == 2'(WAIT_CYCLES - 1)) begin
            state <= ws_done;
          end
        end
        ws_done: begin
          // hold until the strobe ends so one access gets one wait
          if (!any_strobe) begin
            state <= ws_idle;
          end
        end
        default: begin
          state <= ws_idle;
        end
      endcase
    end
  end

  // [R2] two to three clocks
  // ready drops on the edge seen by the sequencer, asynchronous
  // strobe alignment delays the drop up to one clock; the low time stays two clocks
  always_ff @(posedge core_clk) begin
    if (srst) begin
      iochrdy <= 1'b1;
    end else if (clk_en) begin
      iochrdy <= !((state == ws_idle && lead_edge && wait_enable) ||
                   (state == ws_hold &&
                    wait_cnt != 2'(WAIT_CYCLES - 1)));
    end
  end

  // prom enable is observed nowhere in the ready path by design
  logic unused_prom;
  assign unused_prom = prom_window_enable_n;

endmodule

// ---- tb/host_bus_wait_and_latch_properties.sv ----
`timescale 1ns/1ps
// port timing checks, sampled on the crystal clock
module host_bus_checker
  import host_bus_pkg::*;
#(
  parameter logic [2:0]  WIN_BASE = 3'h6,
  parameter logic [8:0]  BUF_BASE = 9'h1a0,
  parameter logic [13:0] IO_BASE  = 14'h00b8
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              clk_en,
  // host side inputs
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic              aen,
  input wire logic              mem_rd_n,
  input wire logic              cfg_wr,
  input wire logic [7:0]        cfg_wdata,
  // outputs under watch
  input wire logic              iochrdy,
  input wire logic              mem_wide_select_n,
  input wire logic              io_wide_select_n,
  input wire logic              upper_lane_buffer_en_n,
  input wire logic              lower_lane_buffer_en_n,
  input wire logic [ADDR_W-1:0] latched_addr,
  input wire logic              wide_mode,
  input wire logic              wait_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // once ready drops it stays low two clocks, then returns
  ready_two_clk_a: assert property (
    $fell(iochrdy) |=> !iochrdy ##1 iochrdy)
    else $error("ready low not two clocks");
  // wait bit clear long enough: no wait may be inserted
  ready_idle_a: assert property (
    !wait_enable [*3] |-> iochrdy)
    else $error("ready dropped with wait off");
  // both lanes always move together
  lane_pair_a: assert property (
    upper_lane_buffer_en_n == lower_lane_buffer_en_n)
    else $error("lane enables differ");
  // lanes only turn on while the read strobe is low
  lane_on_read_a: assert property (
    $fell(lower_lane_buffer_en_n) |-> !mem_rd_n)
    else $error("lanes on without read");
  // sync delay plus one register bounds the release
  lane_release_a: assert property (
    $rose(mem_rd_n) |-> ##[1:6] lower_lane_buffer_en_n)
    else $error("lanes not released");
  // a long read strobe freezes the held address
  addr_hold_a: assert property (
    (!mem_rd_n) [*6] |=> $stable(latched_addr))
    else $error("address moved under strobe");
  // registered decode, skipped after reset or a frozen clock
  mem_sel_a: assert property (
    !$past(srst) && $past(clk_en) |-> mem_wide_select_n ==
    !($past(host_addr[19:17]) == WIN_BASE &&
      $past(latched_addr[19:11]) == BUF_BASE))
    else $error("memory select wrong");
  // io decode uses the live address and aen
  io_sel_a: assert property (
    !$past(srst) && $past(clk_en) |-> io_wide_select_n ==
    !(!$past(aen) && $past(host_addr[15:2]) == IO_BASE))
    else $error("io select wrong");
  // a config write only lands while the clock enable is high
  cfg_load_a: assert property (
    cfg_wr && clk_en |=>
    wait_enable == $past(cfg_wdata[CFG_WAIT_BIT]) &&
    wide_mode == $past(cfg_wdata[CFG_WIDE_BIT]))
    else $error("config bits not loaded");
endmodule
bind host_bus_wait_and_latch host_bus_checker #(.WIN_BASE(WIN_BASE),
  .BUF_BASE(BUF_BASE), .IO_BASE(IO_BASE)) checker_inst (.*);

// ---- tb/host_master_model.sv ----
`timescale 1ns/1ps
// host bus master: one strobe per access, waits on ready
module host_master_model
  import host_bus_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              iochrdy,
  output logic [ADDR_W-1:0]      host_addr,
  output logic                   bale,
  output logic [3:0]             strobe_n
);
  initial begin
    bale = 1'b1;
    strobe_n = 4'hf;
    host_addr = '0;
  end
  // kind 0 mem read, 1 mem write, 2 io read, 3 io write
  task automatic access(input logic [ADDR_W-1:0] a, input logic [1:0] kind,
                        input logic pulse);
    @(posedge core_clk);
    host_addr <= a;
    if (pulse) begin
      // bale falls, then the pins move before the strobe
      @(posedge core_clk);
      bale <= 1'b0;
      repeat (5) @(posedge core_clk);
      host_addr <= ~a;
    end
    @(posedge core_clk);
    strobe_n[kind] <= 1'b0;
    repeat (5) @(posedge core_clk);
    // hold spent: stale address must not be relied on
    host_addr <= ~a;
    repeat (5) @(posedge core_clk);
    for (int i = 0; i < 8 && iochrdy !== 1'b1; i++) @(posedge core_clk);
    strobe_n <= 4'hf;
    repeat (8) @(posedge core_clk);
    // bale back to its idle high level between accesses
    bale <= 1'b1;
  endtask
endmodule

// ---- tb/host_bus_wait_and_latch_bench.sv ----
`timescale 1ns/1ps
module host_bus_wait_and_latch_bench;
  import host_bus_pkg::*;
  localparam logic [19:0] HIT = 20'hd0000;  // buffer window base
  localparam logic [19:0] IOA = 20'h002e0;  // io select address
  logic core_clk, srst, aen, prom, sense_n, cfg_wr, iochrdy;
  logic mem_sel_n, io_sel_n, up_n, lo_n, wide_mode, wait_enable, bale;
  logic [7:0] d, cfg_wdata;
  logic [3:0] sn;
  logic [19:0] addr, host_addr, latched_addr;
  logic [1:0] kind;
  logic en, pulse, aen_v, exp_mem, exp_io;
  logic [19:0] live;  // address the pins show while the strobe is low
  int err_total, compares, rdy_lows, lane_lows;
  host_master_model host_inst (.core_clk(core_clk), .iochrdy(iochrdy),
    .host_addr(host_addr), .bale(bale), .strobe_n(sn));
  host_bus_wait_and_latch host_bus_wait_and_latch_inst (.core_clk(core_clk),
    .srst(srst), .clk_en(en), .host_addr(host_addr), .bale(bale),
    .aen(aen), .mem_rd_n(sn[0]), .mem_wr_n(sn[1]), .io_rd_n(sn[2]),
    .io_wr_n(sn[3]), .prom_window_enable_n(prom),
    .wide_bus_sense_n(sense_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .iochrdy(iochrdy), .mem_wide_select_n(mem_sel_n),
    .io_wide_select_n(io_sel_n), .upper_lane_buffer_en_n(up_n),
    .lower_lane_buffer_en_n(lo_n), .latched_addr(latched_addr),
    .wide_mode(wide_mode), .wait_enable(wait_enable));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // count ready-low and lane-on cycles of each access
  always @(posedge core_clk) begin
    if (iochrdy !== 1'b1) rdy_lows++;
    if (lo_n !== 1'b1) lane_lows++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(20 * 5000);
    err_total++;
    print_verdict;
  end
  initial begin
    srst = 1'b1;
    en = 1'b1;
    aen = 1'b0;
    prom = 1'b1;
    sense_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_wdata = 8'h00;
    void'($urandom(7201));
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(wide_mode, 1);
    check(wait_enable, 0);
    // wait off then on, every cycle type, prom enable both ways;
    // odd passes run 16-bit with bale pulsed, even passes 8-bit
    for (int i = 0; i < 16; i++) begin
      kind = i[1:0];
      pulse = i[0];
      d = 8'($urandom);
      d[2] = i[3];
      d[7] = pulse;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge core_clk);
      cfg_wr <= 1'b0;
      prom <= i[2];
      sense_n <= 1'($urandom);
      aen_v = kind[1] ? 1'b0 : i[0];
      aen <= aen_v;
      addr = kind[1] ? IOA : HIT | (20'($urandom) & 20'h007ff);
      // with bale pulsed the pins already show the moved address
      live = pulse ? ~addr : addr;
      exp_mem = !(live[19:17] == HIT[19:17] && addr[19:11] == HIT[19:11]);
      exp_io = !(!aen_v && live[15:2] == IOA[15:2]);
      @(posedge core_clk);
      check(wide_mode, d[7]);
      rdy_lows = 0;
      lane_lows = 0;
      fork
        host_inst.access(addr, kind, pulse);
        begin
          // first edge that shows a strobe low
          while (sn == 4'hf) @(posedge core_clk);
          repeat (2) @(posedge core_clk);
          check(mem_sel_n, exp_mem);
          check(io_sel_n, exp_io);
          repeat (5) @(posedge core_clk);
          if (!kind[1]) check(latched_addr, addr);
        end
      join
      check(rdy_lows, i[3] ? 2 : 0);
      check(lane_lows != 0, kind == 2'h0);
      check(lo_n, 1);
      check(up_n, 1);
    end
    // frozen clock enable: a config write must not land
    en <= 1'b0;
    cfg_wdata <= ~d;
    cfg_wr <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(wait_enable, d[2]);
    check(wide_mode, d[7]);
    cfg_wr <= 1'b0;
    en <= 1'b1;
    @(posedge core_clk);
    print_verdict;
  end
endmodule
